// >>> rtl/scd_top.sv
`timescale 1ns/1ps
`include "scd_cfg.svh"

// How it works
// - Writing E7H then 18H to the oscillator control address unlocks the divider.
// - After one divider write completes the divider locks again.
// - Reset loads 00H, or 08H when the low-power option bit is 0.
// - A divider of zero passes the oscillator clock straight through.
// - A nonzero divider gives the oscillator rate divided by that value.
// - The divider is one 8-bit read-write register at FF_E0A1H.
module scd_top
    import scd_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // Option strap
    input wire logic LOW_POWER_OPTION_BIT_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [`SCD_ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Clock outputs
    output logic SYS_CLK_TICK_OUT,
    output logic [DIV_W-1:0] SYSTEM_CLOCK_DIVIDE_OUT
);
    if (DIV_W != 8)
    begin : g_bad_div_w
        $error("scd_top: DIV_W must be 8");
    end

    // Byte addresses are four times the word indexes
    if (`SCD_ADDR_W != $bits(`SCD_ADDR_DIVIDE))
    begin : g_bad_addr_w
        $error("scd_top: address width does not fit the map");
    end

    // =================================================================
    // Strap synchroniser and reset tracking
    // =================================================================
    logic opt_meta;
    logic opt_sync;
    logic rst_d;
    logic first_run;

    always_ff @(posedge MCLK_IN)
    begin
        opt_meta <= LOW_POWER_OPTION_BIT_IN;
        opt_sync <= opt_meta;
    end

    // Reset delayed one edge to spot its release
    always_ff @(posedge MCLK_IN)
    begin
        rst_d <= SYS_RST_IN;
    end

    // First edge after release, strap already settled
    assign first_run = rst_d && !SYS_RST_IN;

    // =================================================================
    // APB decode
    // =================================================================
    logic access;
    logic wr_ctrl;
    logic wr_div;
    logic wr_low;
    logic hit;

    function automatic logic addr_is(input logic [`SCD_ADDR_W-1:0] a,
                                     input logic [`SCD_ADDR_W-1:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    function automatic logic key_is(input logic [31:0] data,
                                    input logic [7:0] key);
        key_is = (data[7:0] == key);
    endfunction

    assign access = PSEL_IN && PENABLE_IN && !PREADY_OUT;
    // Only byte lane 0 holds register bits
    assign wr_low = PWRITE_IN && PSTRB_IN[0];
    assign hit = addr_is(PADDR_IN, `SCD_ADDR_OSC_CTRL)
        || addr_is(PADDR_IN, `SCD_ADDR_DIVIDE)
        || addr_is(PADDR_IN, `SCD_ADDR_STATUS);
    assign wr_ctrl = access && wr_low && addr_is(PADDR_IN, `SCD_ADDR_OSC_CTRL);
    assign wr_div = access && wr_low && addr_is(PADDR_IN, `SCD_ADDR_DIVIDE);

    // =================================================================
    // Lock sequencer
    // =================================================================
    scd_lock_state_t lock_state;
    scd_lock_state_t next_lock_state;

    always_comb
    begin
        next_lock_state = lock_state;
        case (lock_state)
            SCD_LOCKED:
            begin
                if (wr_ctrl && key_is(PWDATA_IN, `SCD_UNLOCK_KEY1))
                begin
                    next_lock_state = SCD_KEY1_SEEN;
                end
            end
            SCD_KEY1_SEEN:
            begin
                if (wr_ctrl)
                begin
                    if (key_is(PWDATA_IN, `SCD_UNLOCK_KEY2))
                    begin
                        next_lock_state = SCD_UNLOCKED;
                    end
                    else if (key_is(PWDATA_IN, `SCD_UNLOCK_KEY1))
                    begin
                        next_lock_state = SCD_KEY1_SEEN;
                    end
                    else
                    begin
                        next_lock_state = SCD_LOCKED;
                    end
                end
            end
            SCD_UNLOCKED:
            begin
                // One divider write spends the unlock
                if (wr_div)
                begin
                    next_lock_state = SCD_LOCKED;
                end
            end
            default:
            begin
                next_lock_state = SCD_LOCKED;
            end
        endcase
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            lock_state <= SCD_LOCKED;
        end
        else
        begin
            lock_state <= next_lock_state;
        end
    end

    // =================================================================
    // Divide register
    // =================================================================
    logic [DIV_W-1:0] divide;
    logic div_load;

    function automatic logic [DIV_W-1:0] divide_reset(input logic opt);
        // Option bit low selects the slower start-up rate
        divide_reset = opt ? DIV_W'(`SCD_DIV_RESET) : DIV_W'(`SCD_DIV_RESET_LP);
    endfunction

    // Writes while locked fall through untouched
    assign div_load = wr_div && (lock_state == SCD_UNLOCKED);

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            divide <= `SCD_DIV_RESET;
        end
        else if (first_run)
        begin
            // Strap caught on the first edge after release
            divide <= divide_reset(opt_sync);
        end
        else if (div_load)
        begin
            divide <= PWDATA_IN[DIV_W-1:0];
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            SYSTEM_CLOCK_DIVIDE_OUT <= `SCD_DIV_RESET;
        end
        else
        begin
            SYSTEM_CLOCK_DIVIDE_OUT <= divide;
        end
    end

    // =================================================================
    // APB response
    // =================================================================
    function automatic logic [31:0] status_word(input scd_lock_state_t st,
                                                input logic [DIV_W-1:0] dv);
        logic [31:0] w;
        w = 32'h00000000;
        w[`SCD_STATUS_LOCK_BIT] = (st != SCD_UNLOCKED);
        w[`SCD_STATUS_STAGE_BIT] = (st == SCD_KEY1_SEEN);
        w[`SCD_STATUS_BYPASS_BIT] = (dv == `SCD_DIV_BYPASS);
        status_word = w;
    endfunction

    function automatic logic [31:0] read_word(input logic [`SCD_ADDR_W-1:0] a,
                                              input scd_lock_state_t st,
                                              input logic [DIV_W-1:0] dv);
        logic [31:0] w;
        w = 32'h00000000;
        if (addr_is(a, `SCD_ADDR_DIVIDE))
        begin
            w[DIV_W-1:0] = dv;
        end
        else if (addr_is(a, `SCD_ADDR_STATUS))
        begin
            w = status_word(st, dv);
        end
        // Control location reads back as zero
        read_word = w;
    endfunction

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            PREADY_OUT <= 1'b0;
        end
        else
        begin
            // Exactly one wait state, a one-cycle answer
            PREADY_OUT <= access;
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            PSLVERR_OUT <= 1'b0;
        end
        else
        begin
            PSLVERR_OUT <= access && !hit;
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            PRDATA_OUT <= 32'h00000000;
        end
        else if (access && PWRITE_IN)
        begin
            PRDATA_OUT <= 32'h00000000;
        end
        else if (access)
        begin
            PRDATA_OUT <= read_word(PADDR_IN, lock_state, divide);
        end
    end

    // =================================================================
    // System clock rate
    // =================================================================
    // Tick is an enable pulse, not a gated clock
    logic tick;

    scd_clock_gen #(
        .DIV_W(DIV_W)
    ) u_clock_gen (
        .MCLK_IN(MCLK_IN),
        .SYS_RST_IN(SYS_RST_IN),
        .divide_in(divide),
        .tick_out(tick)
    );

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            SYS_CLK_TICK_OUT <= 1'b0;
        end
        else
        begin
            SYS_CLK_TICK_OUT <= tick;
        end
    end
endmodule // scd_top

// >>> rtl/scd_cfg.svh
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// =====================================================================
// Register map: word indexes, byte address is four times the index
// =====================================================================
`define SCD_ADDR_W 26
`define SCD_IDX_OSC_CTRL 24'hFFE0A0
`define SCD_IDX_DIVIDE 24'hFFE0A1
`define SCD_ADDR_OSC_CTRL {`SCD_IDX_OSC_CTRL, 2'b00}
`define SCD_ADDR_DIVIDE {`SCD_IDX_DIVIDE, 2'b00}
`define SCD_ADDR_STATUS 26'h0000010

// =====================================================================
// Values
// =====================================================================
`define SCD_UNLOCK_KEY1 8'hE7
`define SCD_UNLOCK_KEY2 8'h18
`define SCD_DIV_RESET 8'h00
`define SCD_DIV_RESET_LP 8'h08
`define SCD_DIV_BYPASS 8'h00
`define SCD_STATUS_LOCK_BIT 0
`define SCD_STATUS_STAGE_BIT 1
`define SCD_STATUS_BYPASS_BIT 2

`endif

// >>> rtl/scd_pkg.sv
package scd_pkg;
    typedef enum logic [1:0]
    {
        SCD_LOCKED = 2'b00,
        SCD_KEY1_SEEN = 2'b01,
        SCD_UNLOCKED = 2'b10
    } scd_lock_state_t;
endpackage

// >>> rtl/scd_clock_gen.sv
`timescale 1ns/1ps
`include "scd_cfg.svh"

// =====================================================================
// Clock enable generator: one pulse every divide cycles, or every cycle
// =====================================================================
module scd_clock_gen #(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // Control
    input wire logic [DIV_W-1:0] divide_in,
    // Output
    output logic tick_out
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] divide_q;
    logic wrap;

    if (DIV_W < 1 || DIV_W > 16)
    begin : g_bad_div_w
        $error("scd_clock_gen: DIV_W out of range");
    end

    // Zero and one both give a tick every cycle
    assign wrap = (count >= divide_q - DIV_W'(1)) || (divide_q == DIV_W'(0));

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            count <= '0;
            divide_q <= '0;
        end
        else if (divide_in != divide_q)
        begin
            // Restart on a new rate
            count <= '0;
            divide_q <= divide_in;
        end
        else if (wrap)
        begin
            count <= '0;
        end
        else
        begin
            count <= count + DIV_W'(1);
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= wrap && (divide_in == divide_q);
        end
    end
endmodule // scd_clock_gen

// >>> sim/scd_top_props.sv
`timescale 1ns/1ps
`include "scd_cfg.svh"

// ==========
// Port checker
module scd_top_props #(
    parameter int DIV_W = 8
) (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [`SCD_ADDR_W-1:0] PADDR_IN,
    input wire logic [3:0] PSTRB_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic SYS_CLK_TICK_OUT,
    input wire logic [DIV_W-1:0] SYSTEM_CLOCK_DIVIDE_OUT
);
    logic mapped;
    logic div_hit;
    assign div_hit = PADDR_IN == `SCD_ADDR_DIVIDE;
    assign mapped = div_hit || PADDR_IN == `SCD_ADDR_OSC_CTRL || PADDR_IN == `SCD_ADDR_STATUS;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_access;
        PSEL_IN && PENABLE_IN && !PREADY_OUT;
    endsequence
    sequence s_answer;
        PREADY_OUT ##1 !PREADY_OUT;
    endsequence

    chk_one_wait_state: assert property (s_access |=> s_answer)
        else $error("ready not one cycle after access");
    chk_ready_cause: assert property (PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN))
        else $error("ready without access");
    chk_err_unmapped: assert property (PREADY_OUT && !mapped |-> PSLVERR_OUT)
        else $error("no error on unmapped address");
    chk_err_mapped: assert property (PREADY_OUT && mapped |-> !PSLVERR_OUT)
        else $error("error on mapped address");
    chk_read_divide: assert property (PREADY_OUT && !PWRITE_IN && div_hit
        |-> PRDATA_OUT == {24'h000000, SYSTEM_CLOCK_DIVIDE_OUT})
        else $error("divide read data wrong");
    chk_divide_by_write: assert property ($changed(SYSTEM_CLOCK_DIVIDE_OUT)
        |-> $past(PREADY_OUT && PWRITE_IN && PSTRB_IN[0] && div_hit) || $past(SYS_RST_IN, 3))
        else $error("divide changed without write");
    chk_bypass_tick: assert property ((SYSTEM_CLOCK_DIVIDE_OUT <= 1)[*5] |-> SYS_CLK_TICK_OUT)
        else $error("tick missing in bypass");
    chk_tick_spacing: assert property (SYS_CLK_TICK_OUT && SYSTEM_CLOCK_DIVIDE_OUT >= 2
        && $stable(SYSTEM_CLOCK_DIVIDE_OUT) |=> !SYS_CLK_TICK_OUT)
        else $error("ticks too close");
endmodule // scd_top_props

bind scd_top scd_top_props #(.DIV_W(DIV_W)) u_props (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .SYS_CLK_TICK_OUT(SYS_CLK_TICK_OUT),
    .SYSTEM_CLOCK_DIVIDE_OUT(SYSTEM_CLOCK_DIVIDE_OUT));

// >>> sim/testbench.sv
`timescale 1ns/1ps
`include "scd_cfg.svh"

module testbench;
    logic clk = 0, rst = 1, strap = 0, psel = 0, pen = 0, pwr = 0;
    logic [`SCD_ADDR_W-1:0] padr = 0;
    logic [31:0] pwd = 0, prd, rdata;
    logic rdy, err, rerr, tick;
    logic [7:0] dout;
    int n_fail = 0, checks_done = 0;

    scd_top u_scd_top (.MCLK_IN(clk), .SYS_RST_IN(rst), .LOW_POWER_OPTION_BIT_IN(strap),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd),
        .PSTRB_IN(4'hF), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
        .SYS_CLK_TICK_OUT(tick), .SYSTEM_CLOCK_DIVIDE_OUT(dout));

    initial forever #5 clk = ~clk;

    task end_sim;
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ==========
    // APB master
    task apb(input logic w, input logic [`SCD_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        rdata = prd;
        rerr = err;
        psel <= 0; pen <= 0;
    endtask

    task rd(input logic [`SCD_ADDR_W-1:0] a, input logic [7:0] exp);
        apb(0, a, 0);
        check(rdata, {24'h000000, exp});
    endtask

    task unlock;
        apb(1, `SCD_ADDR_OSC_CTRL, `SCD_UNLOCK_KEY1);
        apb(1, `SCD_ADDR_OSC_CTRL, `SCD_UNLOCK_KEY2);
    endtask

    task per(input int n);
        int c;
        // Let a tick of the old rate drain first
        repeat (2) @(posedge clk);
        c = 0;
        while (tick !== 1'b1 && c < 600)
        begin
            @(posedge clk);
            c++;
        end
        @(posedge clk);
        c = 1;
        while (tick !== 1'b1 && c < 600)
        begin
            @(posedge clk);
            c++;
        end
        check(c, n);
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_sim;
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        rd(`SCD_ADDR_DIVIDE, `SCD_DIV_RESET_LP);
        check(rerr, 0);
        apb(1, `SCD_ADDR_DIVIDE, 32'h00000055);
        rd(`SCD_ADDR_DIVIDE, 8'h08);
        per(8);
        apb(1, `SCD_ADDR_OSC_CTRL, `SCD_UNLOCK_KEY2);
        apb(1, `SCD_ADDR_OSC_CTRL, `SCD_UNLOCK_KEY1);
        apb(1, `SCD_ADDR_DIVIDE, 32'h00000055);
        rd(`SCD_ADDR_DIVIDE, 8'h08);
        rd(`SCD_ADDR_STATUS, 8'h03);
        unlock;
        apb(1, `SCD_ADDR_DIVIDE, 32'h000000FF);
        rd(`SCD_ADDR_DIVIDE, 8'hFF);
        check(dout, 8'hFF);
        per(255);
        apb(1, `SCD_ADDR_DIVIDE, 32'h00000003);
        rd(`SCD_ADDR_DIVIDE, 8'hFF);
        unlock;
        apb(1, `SCD_ADDR_DIVIDE, 32'h00000003);
        per(3);
        unlock;
        apb(1, `SCD_ADDR_DIVIDE, `SCD_DIV_BYPASS);
        per(1);
        rd(`SCD_ADDR_STATUS, 8'h05);
        apb(0, 26'h0000100, 0);
        check(rerr, 1);
        strap <= 1;
        rst <= 1;
        repeat (12) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        rd(`SCD_ADDR_DIVIDE, `SCD_DIV_RESET);
        end_sim;
    end
endmodule // testbench
